// File: pfd_pkg.sv
// Package with shared types and constants for the phase/frequency detector.
package pfd_pkg;

    // Detector states are held as one bit each.
    localparam logic DET_IDLE = 1'b0;
    localparam logic DET_ACTIVE = 1'b1;

    // Default level of the polarity and load strobe inputs when floating.
    localparam logic OPEN_INPUT_LEVEL = 1'b1;

    // Default stretch of every up/down pulse, in clock cycles.
    localparam int PULSE_MIN_CYCLES = 1;

    // Internal up/down request pair.
    typedef struct packed {
        logic up;
        logic down;
    } pump_req_t;

    // Tri-state pump pin: output level and enable.
    typedef struct packed {
        logic level;
        logic oe;
    } pump_pin_t;

    // Output levels held in reset and, except for the monitor, whenever neither detector state is set.
    localparam logic REF_SIDE_IDLE = 1'b0;
    localparam logic VCO_SIDE_IDLE = 1'b1;
    localparam logic LOCK_FLAG_IDLE = 1'b1;
    localparam logic MONITOR_IDLE = 1'b0;
    localparam pump_pin_t PUMP_PIN_OFF = '{level: 1'b0, oe: 1'b0};

endpackage : pfd_pkg

// File: edge_seen.sv
// One edge-triggered detector flip-flop with a sampled-edge front end.
`timescale 1ns/1ps
module edge_seen
    import pfd_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Compared signal and common clear.
    input wire logic i_sig,
    input wire logic i_clear,
    // Detector state.
    output logic o_active,
    output logic o_rise
);

    logic prev_q;
    logic prev_d;
    logic act_q;
    logic act_d;

    // A rising edge sets the state; the common clear drops it, but an edge
    // in the same cycle as the clear wins so no edge is ever lost.
    always_comb begin
        prev_d = i_sig;
        o_rise = i_sig & ~prev_q;
        act_d = act_q;
        if (i_clear) begin
            act_d = DET_IDLE;
        end
        if (o_rise) begin
            act_d = DET_ACTIVE;
        end
    end

    // Registers only.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prev_q <= 1'b0;
            act_q <= DET_IDLE;
        end else begin
            prev_q <= prev_d;
            act_q <= act_d;
        end
    end

    assign o_active = act_q;

endmodule : edge_seen

// File: phase_frequency_detector.sv
// Phase/frequency detector with pump, bypass pump, lock and test outputs.
// Notes on behaviour
// [RULE_01] Sense high, ref leads: VCO output pulses low.
// [RULE_02] Sense high, ref lags: ref output pulses high.
// [RULE_03] Sense low, ref lags: VCO output pulses low.
// [RULE_04] Sense low, ref leads: ref output pulses high.
// [RULE_05] In lock: VCO output high, ref low.
// [RULE_06] Half-cycle phase gives at least half duty.
// [RULE_07] Pump drives by sense and error; Z in lock.
// [RULE_08] Test pin: ref if sense high, else VCO.
// [RULE_09] Floating sense input reads as high.
// [RULE_10] Lock flag is NOR of up and down.
// [RULE_11] Strobe high: bypass pump follows main pump.
// [RULE_12] Strobe low: bypass pump high impedance.
// [RULE_13] Compare leading (rising) edges of both inputs.
// [RULE_14] Clear both states once both edges seen.
`timescale 1ns/1ps
module phase_frequency_detector
    import pfd_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Divided inputs to compare.
    input wire logic i_ref_compare_in,
    input wire logic i_vco_compare_in,
    // Control pins and their floating indicators.
    input wire logic i_phase_sense_select,
    input wire logic i_phase_sense_open,
    input wire logic i_load_strobe,
    input wire logic i_load_strobe_open,
    // Digital comparator outputs.
    output logic o_ref_side_out,
    output logic o_vco_side_out,
    // Charge pump pins as level and enable.
    output logic o_pump_out,
    output logic o_pump_oe,
    output logic o_bypass_pump_out,
    output logic o_bypass_pump_oe,
    // Lock flag and test monitor.
    output logic o_lock_flag,
    output logic o_test_monitor
);

    pump_req_t req;
    logic both_seen;
    logic sense;
    logic strobe;
    logic lead;
    logic lag;
    pump_pin_t pump_d;
    pump_pin_t pump_q;
    pump_pin_t byp_d;
    pump_pin_t byp_q;
    logic ref_out_d;
    logic ref_out_q;
    logic vco_out_d;
    logic vco_out_q;
    logic lock_d;
    logic lock_q;
    logic mon_d;
    logic mon_q;

    // A floating control pin reads as its pulled level. Both control pins
    // share this, so a board that leaves them open gets the default mode.
    function automatic logic pin_level(input logic lvl, input logic floats);
        return floats ? OPEN_INPUT_LEVEL : lvl; // [RULE_09] [RULE_11]
    endfunction : pin_level

    // A driven pump pin at the given level.
    function automatic pump_pin_t drive_pin(input logic lvl);
        return '{level: lvl, oe: 1'b1};
    endfunction : drive_pin

    // Resolved control levels.
    assign sense = pin_level(i_phase_sense_select, i_phase_sense_open);
    assign strobe = pin_level(i_load_strobe, i_load_strobe_open);

    // Up follows reference edges, down follows VCO edges.
    edge_seen u_ref_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sig(i_ref_compare_in), // [RULE_13]
        .i_clear(both_seen),
        .o_active(req.up),
        .o_rise()
    );

    edge_seen u_vco_edge (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sig(i_vco_compare_in), // [RULE_13]
        .i_clear(both_seen),
        .o_active(req.down),
        .o_rise()
    );

    // Clearing as soon as both are set keeps the overlap to one cycle, a
    // short spike that avoids a dead band near lock.
    assign both_seen = req.up & req.down; // [RULE_14]

    // Direction of the pending phase error, decoded once for the comparator and pump groups.
    // A lone up state means the reference leads and a lone down state that
    // it lags; none or both leave no net correction to apply.
    always_comb begin
        lead = req.up & ~req.down;
        lag = req.down & ~req.up;
    end

    // Comparator outputs. The up state lasts from one leading edge to the
    // other, so a half-cycle offset shows as half duty at least. During the
    // one-cycle overlap both pins keep their locked levels, so the spike
    // that fights the dead band only appears on the lock flag.
    always_comb begin
        ref_out_d = REF_SIDE_IDLE; // [RULE_05]
        vco_out_d = VCO_SIDE_IDLE; // [RULE_05]
        if (lead) begin
            // Reference leads: the VCO must speed up.
            if (sense) begin
                vco_out_d = ~VCO_SIDE_IDLE; // [RULE_01] [RULE_06]
            end else begin
                ref_out_d = ~REF_SIDE_IDLE; // [RULE_04] [RULE_06]
            end
        end else if (lag) begin
            // Reference lags: the VCO must slow down.
            if (sense) begin
                ref_out_d = ~REF_SIDE_IDLE; // [RULE_02] [RULE_06]
            end else begin
                vco_out_d = ~VCO_SIDE_IDLE; // [RULE_03] [RULE_06]
            end
        end
    end

    // Comparator output registers.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ref_out_q <= REF_SIDE_IDLE;
            vco_out_q <= VCO_SIDE_IDLE;
        end else begin
            ref_out_q <= ref_out_d;
            vco_out_q <= vco_out_d;
        end
    end

    // Main pump: pushes up when the VCO is slow and the sense pin is high,
    // the other way round when it is low, and floats with no net error.
    always_comb begin
        pump_d = PUMP_PIN_OFF; // [RULE_05] [RULE_07]
        if (lead) begin
            pump_d = drive_pin(sense); // [RULE_07]
        end else if (lag) begin
            pump_d = drive_pin(~sense); // [RULE_07]
        end
    end

    // Main pump register.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pump_q <= PUMP_PIN_OFF;
        end else begin
            pump_q <= pump_d;
        end
    end

    // Bypass pump copies the next main pump value rather than the register,
    // so both pins move on the same edge and never disagree for a cycle.
    always_comb begin
        byp_d = PUMP_PIN_OFF; // [RULE_12]
        if (strobe) begin
            byp_d = pump_d; // [RULE_11]
        end
    end

    // Bypass pump register.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            byp_q <= PUMP_PIN_OFF;
        end else begin
            byp_q <= byp_d;
        end
    end

    // Lock flag is the NOR of the two detector states; it goes low for the
    // overlap cycle too, which is the spike a lock filter must absorb.
    always_comb begin
        lock_d = ~(req.up | req.down); // [RULE_10]
    end

    // Lock flag register.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            lock_q <= LOCK_FLAG_IDLE;
        end else begin
            lock_q <= lock_d;
        end
    end

    // Test monitor shows the compared input that the sense pin picks. It
    // lags that input by one cycle, the price of a registered pin.
    always_comb begin
        mon_d = sense ? i_ref_compare_in : i_vco_compare_in; // [RULE_08]
    end

    // Test monitor register.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mon_q <= MONITOR_IDLE;
        end else begin
            mon_q <= mon_d;
        end
    end

    // Pin assignments.
    assign o_ref_side_out = ref_out_q;
    assign o_vco_side_out = vco_out_q;
    assign o_pump_out = pump_q.level;
    assign o_pump_oe = pump_q.oe;
    assign o_bypass_pump_out = byp_q.level;
    assign o_bypass_pump_oe = byp_q.oe;
    assign o_lock_flag = lock_q;
    assign o_test_monitor = mon_q;

endmodule : phase_frequency_detector

// File: pfd_props.sv
// Checker for the phase/frequency detector ports.
`timescale 1ns/1ps
module pfd_props (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Compared inputs and control pins.
    input wire logic i_ref_compare_in,
    input wire logic i_vco_compare_in,
    input wire logic i_phase_sense_select,
    input wire logic i_phase_sense_open,
    input wire logic i_load_strobe,
    input wire logic i_load_strobe_open,
    // Watched outputs.
    input wire logic o_ref_side_out,
    input wire logic o_vco_side_out,
    input wire logic o_pump_out,
    input wire logic o_pump_oe,
    input wire logic o_bypass_pump_out,
    input wire logic o_bypass_pump_oe,
    input wire logic o_lock_flag,
    input wire logic o_test_monitor
);
    // Effective pin levels, since a floating pin reads high.
    wire logic s = i_phase_sense_select | i_phase_sense_open;
    wire logic b = i_load_strobe | i_load_strobe_open;
    wire logic src = s ? i_ref_compare_in : i_vco_compare_in;
    wire logic up = o_pump_oe && (o_pump_out == s);
    wire logic dn = o_pump_oe && (o_pump_out != s);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_up; up |-> o_ref_side_out != s && o_vco_side_out != s;
    endproperty
    a_up: assert property (p_up)
        else $error("lead sense");
    property p_dn; dn |-> o_ref_side_out == s && o_vco_side_out == s;
    endproperty
    a_dn: assert property (p_dn)
        else $error("lag sense");
    property p_idle; !o_pump_oe |-> !o_ref_side_out && o_vco_side_out;
    endproperty
    a_idle: assert property (p_idle)
        else $error("lock levels");
    // The overlap of both states pulls the flag low with the pump off, so
    // only one direction is checked: a driven pump forces the flag low.
    property p_lock; o_pump_oe |-> !o_lock_flag; endproperty
    a_lock: assert property (p_lock)
        else $error("lock flag");
    // A spike with the pump off lasts one cycle at most.
    property p_spike; !o_lock_flag && !o_pump_oe |=>
        o_lock_flag || o_pump_oe; endproperty
    a_spike: assert property (p_spike)
        else $error("spike length");
    property p_mon; $stable(s) |-> o_test_monitor == $past(src); endproperty
    a_mon: assert property (p_mon)
        else $error("monitor");
    property p_bon; b && $stable(b) && o_pump_oe |->
        o_bypass_pump_oe && o_bypass_pump_out == o_pump_out; endproperty
    a_bon: assert property (p_bon)
        else $error("bypass on");
    property p_boff; !b && $stable(b) |-> !o_bypass_pump_oe; endproperty
    a_boff: assert property (p_boff)
        else $error("bypass off");
    // A lone reference edge from lock pulls the flag low two edges on.
    property p_go; $rose(i_ref_compare_in) && !$rose(i_vco_compare_in)
        && o_lock_flag |-> ##2 !o_lock_flag; endproperty
    a_go: assert property (p_go)
        else $error("edge latency");
    c_up: cover property (up);
    c_dn: cover property (dn);
    c_byp: cover property (o_bypass_pump_oe);
    c_spike: cover property (!o_lock_flag && !o_pump_oe);
endmodule : pfd_props
bind phase_frequency_detector pfd_props u_props (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ref_compare_in(i_ref_compare_in),
    .i_vco_compare_in(i_vco_compare_in),
    .i_phase_sense_select(i_phase_sense_select),
    .i_phase_sense_open(i_phase_sense_open),
    .i_load_strobe(i_load_strobe),
    .i_load_strobe_open(i_load_strobe_open),
    .o_ref_side_out(o_ref_side_out),
    .o_vco_side_out(o_vco_side_out),
    .o_pump_out(o_pump_out),
    .o_pump_oe(o_pump_oe),
    .o_bypass_pump_out(o_bypass_pump_out),
    .o_bypass_pump_oe(o_bypass_pump_oe),
    .o_lock_flag(o_lock_flag),
    .o_test_monitor(o_test_monitor)
);

// File: vco_edge_model.sv
// Divided VCO edge source standing in for the far-side loop.
`timescale 1ns/1ps
module vco_edge_model (
    // Clock, fire command and divided VCO line.
    input wire logic i_clk,
    input wire logic i_fire,
    output logic o_vco = 1'h0
);
    logic [2:0] cnt_q = 3'h0;
    // Each command gives one six-cycle high pulse, then the line rests low.
    always @(posedge i_clk) begin
        if (i_fire) begin
            o_vco <= 1'h1;
            cnt_q <= 3'h5;
        end else if (cnt_q != 3'h0) begin
            cnt_q <= cnt_q - 3'h1;
        end else begin
            o_vco <= 1'h0;
        end
    end
endmodule : vco_edge_model

// File: phase_frequency_detector_bench.sv
// Self-checking bench for the phase/frequency detector.
`timescale 1ns/1ps
module phase_frequency_detector_bench;
    logic i_clk = 1'h0, i_rst_b = 1'h0, i_ref_compare_in = 1'h0, fire = 1'h0;
    logic i_phase_sense_select = 1'h1, i_phase_sense_open = 1'h0;
    logic i_load_strobe = 1'h1, i_load_strobe_open = 1'h0, i_vco_compare_in;
    logic o_ref_side_out, o_vco_side_out, o_pump_out, o_pump_oe, o_lock_flag;
    logic o_bypass_pump_out, o_bypass_pump_oe, o_test_monitor;
    int errors = 0, cmp_count = 0;
    // Half period of 2.5 ns gives 200 MHz.
    always #2.5 i_clk = ~i_clk;
    vco_edge_model u_vco (.i_clk, .i_fire(fire), .o_vco(i_vco_compare_in));
    phase_frequency_detector dut (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ref_compare_in(i_ref_compare_in),
        .i_vco_compare_in(i_vco_compare_in),
        .i_phase_sense_select(i_phase_sense_select),
        .i_phase_sense_open(i_phase_sense_open),
        .i_load_strobe(i_load_strobe),
        .i_load_strobe_open(i_load_strobe_open),
        .o_ref_side_out(o_ref_side_out),
        .o_vco_side_out(o_vco_side_out),
        .o_pump_out(o_pump_out),
        .o_pump_oe(o_pump_oe),
        .o_bypass_pump_out(o_bypass_pump_out),
        .o_bypass_pump_oe(o_bypass_pump_oe),
        .o_lock_flag(o_lock_flag),
        .o_test_monitor(o_test_monitor)
    );
    task check(input string n, input logic seen, input logic exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %b seen %b", n, exp, seen);
        end
    endtask : check
    task test_done;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    // Raise one input; outputs settle one edge after it is sampled.
    task rise(input logic r);
        @(posedge i_clk);
        if (r) i_ref_compare_in <= 1'h1;
        else fire <= 1'h1;
        @(posedge i_clk);
        fire <= 1'h0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask : rise
    // One leading edge on each input, one after the other, under a given pin setting.
    task t_pair(input logic s, so, ld, lb, lo);
        logic x;
        logic m;
        logic y;
        x = (s | so) ^ ld;
        m = (s | so) ? ld : !ld;
        y = (lb | lo) & !x;
        @(posedge i_clk);
        i_phase_sense_select <= s;
        i_phase_sense_open <= so;
        i_load_strobe <= lb;
        i_load_strobe_open <= lo;
        rise(ld);
        check("ref", o_ref_side_out, x);
        check("vco", o_vco_side_out, x);
        check("pump", o_pump_out, !x);
        check("lock", o_lock_flag, 1'h0);
        check("byp", o_bypass_pump_oe, lb | lo);
        check("bypl", o_bypass_pump_out, y);
        check("mon", o_test_monitor, m);
        rise(!ld);
        check("oe", o_pump_oe, 1'h0);
        check("relock", o_lock_flag, 1'h1);
        check("ref idle", o_ref_side_out, 1'h0);
        check("vco idle", o_vco_side_out, 1'h1);
        @(posedge i_clk);
        i_ref_compare_in <= 1'h0;
        repeat (8) @(posedge i_clk);
    endtask : t_pair
    // Coincident edges keep the comparator and pump outputs locked; the
    // lock flag only shows the one-cycle overlap of both states.
    task t_lock;
        @(posedge i_clk);
        fire <= 1'h1;
        @(posedge i_clk);
        fire <= 1'h0;
        i_ref_compare_in <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            @(posedge i_clk);
            #1;
            check("lock", o_lock_flag, k != 1);
            check("ref", o_ref_side_out, 1'h0);
            check("vco", o_vco_side_out, 1'h1);
            check("oe", o_pump_oe, 1'h0);
        end
        @(posedge i_clk);
        i_ref_compare_in <= 1'h0;
        repeat (8) @(posedge i_clk);
    endtask : t_lock
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'h1;
        t_lock;
        for (int i = 0; i < 32; i++) t_pair(i[0], i[1], i[2], i[3], i[4]);
        test_done;
    end
    // Thirty-two pairs take about 640 cycles; the limit leaves ample room.
    initial begin
        repeat (5000) @(posedge i_clk);
        errors++;
        test_done;
    end
endmodule : phase_frequency_detector_bench
